// >>> design/ptc_pkg.sv
// ptc_pkg: constants for the second transmit control register block.
// assumes a 50 MHz mac clock and an 8-bit host register port.
package ptc_pkg;

  // register map
  localparam logic [15:0] PTC_ADDR_TX_CTL2   = 16'h1a05;
  localparam logic [7:0]  PTC_RESET_TX_CTL2  = 8'h10;

  // field positions of transmit_control_second
  localparam int unsigned PTC_BIT_HARD_RESET = 2;
  localparam int unsigned PTC_BIT_QPTR_CLR   = 3;
  localparam int unsigned PTC_BIT_CHAN_IDLE  = 4;
  localparam int unsigned PTC_BIT_CABLE_RST  = 5;

  // reset values of the stored fields
  localparam logic        PTC_RST_CABLE      = 1'b0;
  localparam logic        PTC_RST_HARD       = 1'b0;
  localparam logic        PTC_RST_CHAN_IDLE  = 1'b1;

  // timing
  localparam int unsigned PTC_CLK_PERIOD_NS  = 20;
  localparam int unsigned PTC_LINE_IDLE_NS   = 12000;
  localparam int unsigned PTC_LINE_IDLE_CYC  =
    (PTC_LINE_IDLE_NS + PTC_CLK_PERIOD_NS - 1) / PTC_CLK_PERIOD_NS;
  localparam int unsigned PTC_IDLE_CNT_W     = 10;

  // kind of frame handed to the transmitter
  typedef enum logic [1:0] {
    PTC_KIND_PACKET = 2'h0,
    PTC_KIND_HARD   = 2'h1,
    PTC_KIND_CABLE  = 2'h2
  } ptc_kind_t;

endpackage

// >>> design/ptc_reg_if.sv
// ptc_reg_if: decoded register strobes between decoder and core.
// assumes both ends on the same mac clock.
`timescale 1ns/1ps
interface ptc_reg_if;
  logic       wr_cable;
  logic       wr_hard;
  logic       wr_qclr;
  logic [7:0] rd_word;

  modport dec  (output wr_cable, output wr_hard, output wr_qclr, input rd_word);
  modport core (input wr_cable, input wr_hard, input wr_qclr, output rd_word);
endinterface

// >>> design/ptc_line_idle.sv
// ptc_line_idle: line idle timer for the biphase-mark-coded line.
// assumes the activity input comes from a pin, asynchronous to clk.
`timescale 1ns/1ps
module ptc_line_idle
  import ptc_pkg::*;
(
  // clock and reset
  input  wire logic clk,
  input  wire logic rstn,
  // line
  input  wire logic line_in,
  // status
  output logic      line_busy
);

  logic                      sync1_q;
  logic                      sync2_q;
  logic                      prev_q;
  logic [PTC_IDLE_CNT_W-1:0] cnt_q;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      sync1_q <= 1'b0;
      sync2_q <= 1'b0;
      prev_q  <= 1'b0;
    end else begin
      sync1_q <= line_in;
      sync2_q <= sync1_q;
      prev_q  <= sync2_q;
    end
  end

  // any transition restarts the idle window
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cnt_q <= '0;
    end else if (sync2_q != prev_q) begin
      cnt_q <= PTC_IDLE_CNT_W'(PTC_LINE_IDLE_CYC);
    end else if (cnt_q != '0) begin
      cnt_q <= cnt_q - 1'b1;
    end
  end

  assign line_busy = (cnt_q != '0);

endmodule // ptc_line_idle

// >>> design/ptc_reg_dec.sv
// ptc_reg_dec: address decode and registered read data for the register.
// assumes single-cycle write and read strobes on the mac clock.
`timescale 1ns/1ps
module ptc_reg_dec
  import ptc_pkg::*;
(
  // clock and reset
  input  wire logic  clk,
  input  wire logic  rstn,
  // host register port
  input  wire logic [15:0] reg_addr,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  input  wire logic [7:0]  reg_wdata,
  output logic [7:0]       reg_rdata,
  // to the core
  ptc_reg_if.dec           rif
);

  logic hit;
  logic wr_hit;

  assign hit    = (reg_addr == PTC_ADDR_TX_CTL2);
  assign wr_hit = reg_wr && hit;

  assign rif.wr_cable = wr_hit && reg_wdata[PTC_BIT_CABLE_RST];
  assign rif.wr_hard  = wr_hit && reg_wdata[PTC_BIT_HARD_RESET];
  assign rif.wr_qclr  = wr_hit && reg_wdata[PTC_BIT_QPTR_CLR];

  // unmapped reads return zero
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      reg_rdata <= hit ? rif.rd_word : 8'h00;
    end
  end

endmodule // ptc_reg_dec

// >>> design/pd_tx_control_b.sv
// pd_tx_control_b: second transmit control register with launch sequencing.
// assumes the transmitter pulses tx_done once per finished frame.
// What this block does
// - launch with cable request and no hard request in auto mode sends cable reset, queue ignored
// - raw mode ignores the cable request; software queues such packets itself
// - cable request accepted only while launch bit is clear
// - hard request written together with cable request wins; cable stays clear
// - cable request cleared when any packet transmission completes
// - mac reset returns the cable request to zero
// - cable request is write-one-to-set; writing zero does nothing
// - read-only channel idle flag, one after reset, one means may launch
// - channel idle flag low while line idle timer says busy
// - channel idle flag low while an automatic response is processed
// - writing one to queue pointer clear resets the queue write pointer
// - queue pointer clear is not stored and reads zero
// - queue write pointer also reset when tx_done clears the launch bit; a mac reset clears it without a reset
// - launch with hard request in auto mode sends hard reset, queue ignored
`timescale 1ns/1ps
module pd_tx_control_b
  import ptc_pkg::*;
(
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rstn,
  input  wire logic        mac_reset,
  // host register port
  input  wire logic [15:0] reg_addr,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  input  wire logic [7:0]  reg_wdata,
  output logic [7:0]       reg_rdata,
  // launch control
  input  wire logic        launch_wr,
  input  wire logic        auto_mode,
  output logic             launch_bit,
  // transmitter
  input  wire logic        tx_done,
  output logic             tx_start,
  output ptc_kind_t        tx_kind,
  output logic             queue_ptr_clear,
  // channel state
  input  wire logic        cc_line_in,
  input  wire logic        auto_resp_busy,
  output logic             channel_idle_flag
);

  typedef enum logic [1:0] {
    PTC_ST_IDLE = 2'b01,
    PTC_ST_SEND = 2'b10
  } ptc_state_t;

  ptc_reg_if rif ();

  ptc_state_t state_q;
  ptc_state_t state_d;
  logic       cable_q;
  logic       cable_d;
  logic       hard_q;
  logic       hard_d;
  logic       idle_q;
  logic       line_busy;
  logic       go_take;
  logic       done_take;
  ptc_kind_t  kind_d;

  ptc_reg_dec u_dec (
    .clk       (clk),
    .rstn      (rstn),
    .reg_addr  (reg_addr),
    .reg_wr    (reg_wr),
    .reg_rd    (reg_rd),
    .reg_wdata (reg_wdata),
    .reg_rdata (reg_rdata),
    .rif       (rif.dec)
  );

  ptc_line_idle u_idle (
    .clk       (clk),
    .rstn      (rstn),
    .line_in   (cc_line_in),
    .line_busy (line_busy)
  );

  // launch accepted only from idle, completion only while sending
  assign go_take   = launch_wr && (state_q == PTC_ST_IDLE) && !mac_reset;
  assign done_take = tx_done && (state_q == PTC_ST_SEND);

  // launch state
  always_comb begin
    state_d = state_q;
    case (state_q)
      PTC_ST_IDLE: begin
        if (go_take) begin
          state_d = PTC_ST_SEND;
        end
      end
      PTC_ST_SEND: begin
        if (done_take) begin
          state_d = PTC_ST_IDLE;
        end
      end
      default: begin
        state_d = PTC_ST_IDLE;
      end
    endcase
    if (mac_reset) begin
      state_d = PTC_ST_IDLE;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state_q <= PTC_ST_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  assign launch_bit = (state_q == PTC_ST_SEND);

  // hard reset request: set only while launch bit is clear
  always_comb begin
    hard_d = hard_q;
    if (done_take) begin
      hard_d = 1'b0;
    end
    if (rif.wr_hard && !launch_bit) begin
      hard_d = 1'b1;
    end
    if (mac_reset) begin
      hard_d = PTC_RST_HARD;
    end
  end

  // cable reset request: write-one-to-set, self-clearing
  always_comb begin
    cable_d = cable_q;
    if (done_take) begin
      cable_d = 1'b0;
    end
    if (rif.wr_cable && !launch_bit && !rif.wr_hard) begin
      cable_d = 1'b1;
    end
    if (mac_reset) begin
      cable_d = PTC_RST_CABLE;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cable_q <= PTC_RST_CABLE;
      hard_q  <= PTC_RST_HARD;
    end else begin
      cable_q <= cable_d;
      hard_q  <= hard_d;
    end
  end

  // frame kind chosen at launch; requests written in the same cycle count
  always_comb begin
    kind_d = PTC_KIND_PACKET;
    if (auto_mode) begin
      if (hard_d) begin
        kind_d = PTC_KIND_HARD;
      end else if (cable_d) begin
        kind_d = PTC_KIND_CABLE;
      end
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      tx_start <= 1'b0;
      tx_kind  <= PTC_KIND_PACKET;
    end else begin
      tx_start <= go_take;
      if (go_take) begin
        tx_kind <= kind_d;
      end
    end
  end

  // pointer clear on write or when tx_done drops the launch bit
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      queue_ptr_clear <= 1'b0;
    end else begin
      queue_ptr_clear <= rif.wr_qclr || done_take;
    end
  end

  // channel idle flag
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      idle_q <= PTC_RST_CHAN_IDLE;
    end else begin
      idle_q <= !line_busy && !auto_resp_busy;
    end
  end

  assign channel_idle_flag = idle_q;

  // read word; pointer clear bit never stored
  always_comb begin
    rif.rd_word = 8'h00;
    rif.rd_word[PTC_BIT_CABLE_RST]  = cable_q;
    rif.rd_word[PTC_BIT_CHAN_IDLE]  = idle_q;
    rif.rd_word[PTC_BIT_HARD_RESET] = hard_q;
  end

endmodule // pd_tx_control_b

// >>> verif/ptc_chk.sv
// ptc_chk: port assertions for pd_tx_control_b.
// assumes a bind to the top module, one mac clock domain.
`timescale 1ns/1ps
module ptc_chk
  import ptc_pkg::*;
(
  // clock and reset
  input wire logic        clk,
  input wire logic        rstn,
  input wire logic        mac_reset,
  // register port
  input wire logic [15:0] reg_addr,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [7:0]  reg_wdata,
  input wire logic [7:0]  reg_rdata,
  // launch and transmitter
  input wire logic        launch_wr,
  input wire logic        auto_mode,
  input wire logic        launch_bit,
  input wire logic        tx_done,
  input wire logic        tx_start,
  input wire ptc_kind_t   tx_kind,
  input wire logic        queue_ptr_clear,
  // channel
  input wire logic        cc_line_in,
  input wire logic        auto_resp_busy,
  input wire logic        channel_idle_flag
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  wire launch_ok = launch_wr && !launch_bit && !mac_reset;
  property p_start; launch_ok |=> tx_start && launch_bit; endproperty
  a_start: assert property (p_start) else $error("launch not taken");
  property p_raw; launch_ok && !auto_mode |=> tx_kind == PTC_KIND_PACKET; endproperty
  a_raw: assert property (p_raw) else $error("raw launch not packet");
  property p_done; tx_done && launch_bit && !mac_reset |=> !launch_bit && queue_ptr_clear;
  endproperty
  a_done: assert property (p_done) else $error("done not handled");
  property p_qclr;
    reg_wr && reg_addr == PTC_ADDR_TX_CTL2 && reg_wdata[PTC_BIT_QPTR_CLR] |=> queue_ptr_clear;
  endproperty
  a_qclr: assert property (p_qclr) else $error("no pointer clear");
  property p_resp; auto_resp_busy |=> !channel_idle_flag; endproperty
  a_resp: assert property (p_resp) else $error("idle during response");
  property p_line; $changed(cc_line_in) |-> ##[1:6] !channel_idle_flag; endproperty
  a_line: assert property (p_line) else $error("idle with busy line");
  property p_rd3; reg_rd |=> !reg_rdata[3]; endproperty
  a_rd3: assert property (p_rd3) else $error("pointer clear read back");
  property p_mrst; mac_reset |=> !launch_bit; endproperty
  a_mrst: assert property (p_mrst) else $error("mac reset kept launch");
endmodule // ptc_chk

// >>> verif/ptc_tx_model.sv
// ptc_tx_model: transmitter side, ends each frame dly+1 cycles after tx_start.
// assumes dly is at least one when a frame starts.
`timescale 1ns/1ps
module ptc_tx_model (
  // clock and reset
  input wire logic       clk,
  input wire logic       rstn,
  // frame start and length
  input wire logic       tx_start,
  input wire logic [7:0] dly,
  // frame end
  output logic           tx_done
);
  logic [7:0] cnt_q;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cnt_q <= 8'h0;
      tx_done <= 1'b0;
    end else begin
      tx_done <= (cnt_q == 8'h1);
      if (tx_start) cnt_q <= dly;
      else if (cnt_q != 8'h0) cnt_q <= cnt_q - 8'h1;
    end
  end
endmodule // ptc_tx_model

// >>> verif/pd_tx_control_b_test.sv
// pd_tx_control_b_test: self-checking bench for the register block.
// assumes ptc_tx_model closes frames; checker bound below.
`timescale 1ns/1ps
module pd_tx_control_b_test;
  import ptc_pkg::*;
  localparam logic [15:0] ra = PTC_ADDR_TX_CTL2;
  logic        clk = 0, rstn = 0, mac_reset = 0, reg_wr = 0, reg_rd = 0, launch_wr = 0;
  logic        auto_mode = 1, cc_line_in = 0, auto_resp_busy = 0, tx_done;
  logic [15:0] reg_addr = 16'h0;
  logic [7:0]  reg_wdata = 8'h0, dly = 8'h2, reg_rdata;
  logic        launch_bit, tx_start, queue_ptr_clear, channel_idle_flag;
  ptc_kind_t   tx_kind;
  int          num_errors = 0, checks = 0;
  always #10 clk = ~clk;
  pd_tx_control_b i_dut (.clk(clk), .rstn(rstn), .mac_reset(mac_reset), .reg_addr(reg_addr),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .launch_wr(launch_wr), .auto_mode(auto_mode), .launch_bit(launch_bit), .tx_done(tx_done),
    .tx_start(tx_start), .tx_kind(tx_kind), .queue_ptr_clear(queue_ptr_clear),
    .cc_line_in(cc_line_in), .auto_resp_busy(auto_resp_busy),
    .channel_idle_flag(channel_idle_flag));
  ptc_tx_model i_model (.clk(clk), .rstn(rstn), .tx_start(tx_start), .dly(dly),
    .tx_done(tx_done));
  task automatic conclude;
    if (num_errors == 0 && checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic chk(string what, logic [7:0] seen, logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr(logic [15:0] a, logic [7:0] d);
    @(posedge clk) {reg_addr, reg_wdata, reg_wr} <= {a, d, 1'b1};
    @(posedge clk) reg_wr <= 1'b0;
  endtask
  task automatic rd(logic [15:0] a, logic [7:0] exp);
    @(posedge clk) {reg_addr, reg_rd} <= {a, 1'b1};
    @(posedge clk) reg_rd <= 1'b0;
    @(negedge clk) chk("rdata", reg_rdata, exp);
  endtask
  task automatic launch(ptc_kind_t k, logic [7:0] d);
    chk("idle flag", {7'h0, channel_idle_flag}, 8'h1);
    @(posedge clk) {launch_wr, dly} <= {1'b1, d};
    @(posedge clk) launch_wr <= 1'b0;
    @(negedge clk) chk("kind", {6'h0, tx_kind}, {6'h0, k});
    chk("start", {7'h0, tx_start}, 8'h1);
    chk("launch", {7'h0, launch_bit}, 8'h1);
  endtask
  task automatic idle_wait;
    for (int i = 0; i < 300; i++) begin
      @(negedge clk);
      if (!launch_bit) return;
    end
    num_errors++;
    conclude();
  endtask
  initial begin
    logic [15:0] a;
    void'($urandom(25));
    repeat (10) @(posedge clk);
    rstn <= 1'b1;
    rd(ra, 8'h10);
    wr(ra, 8'h20);
    wr(ra, 8'h00);
    rd(ra, 8'h30);
    launch(PTC_KIND_CABLE, 8'($urandom_range(1, 40)));
    idle_wait();
    chk("qclr", {7'h0, queue_ptr_clear}, 8'h1);
    rd(ra, 8'h10);
    wr(ra, 8'h20);
    launch(PTC_KIND_CABLE, 8'h1);
    idle_wait();
    wr(ra, 8'h24);
    rd(ra, 8'h14);
    launch(PTC_KIND_HARD, 8'($urandom_range(1, 40)));
    idle_wait();
    rd(ra, 8'h10);
    launch(PTC_KIND_PACKET, 8'h3c);
    wr(ra, 8'h20);
    rd(ra, 8'h10);
    idle_wait();
    @(posedge clk) auto_mode <= 1'b0;
    wr(ra, 8'h20);
    launch(PTC_KIND_PACKET, 8'h1);
    idle_wait();
    wr(ra, 8'h08);
    @(negedge clk) chk("qclr", {7'h0, queue_ptr_clear}, 8'h1);
    rd(ra, 8'h10);
    for (int i = 0; i < 3; i++) begin
      a = 16'($urandom());
      if (a == ra) a = ~a;
      wr(a, 8'($urandom()));
      rd(a, 8'h00);
    end
    rd(ra, 8'h10);
    wr(ra, 8'h20);
    @(posedge clk) mac_reset <= 1'b1;
    @(posedge clk) mac_reset <= 1'b0;
    rd(ra, 8'h10);
    launch(PTC_KIND_PACKET, 8'h20);
    @(posedge clk) mac_reset <= 1'b1;
    @(posedge clk) mac_reset <= 1'b0;
    @(negedge clk) chk("launch", {7'h0, launch_bit}, 8'h0);
    @(posedge clk) auto_resp_busy <= 1'b1;
    @(negedge clk);
    @(negedge clk) chk("idle flag", {7'h0, channel_idle_flag}, 8'h0);
    @(posedge clk) auto_resp_busy <= 1'b0;
    repeat (5) @(posedge clk) cc_line_in <= ~cc_line_in;
    repeat (6) @(posedge clk);
    @(negedge clk) chk("idle flag", {7'h0, channel_idle_flag}, 8'h0);
    repeat (620) @(posedge clk);
    @(negedge clk) chk("idle flag", {7'h0, channel_idle_flag}, 8'h1);
    conclude();
  end
endmodule // pd_tx_control_b_test
bind pd_tx_control_b ptc_chk u_chk (.clk(clk), .rstn(rstn), .mac_reset(mac_reset),
  .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
  .reg_rdata(reg_rdata), .launch_wr(launch_wr), .auto_mode(auto_mode),
  .launch_bit(launch_bit), .tx_done(tx_done), .tx_start(tx_start), .tx_kind(tx_kind),
  .queue_ptr_clear(queue_ptr_clear), .cc_line_in(cc_line_in),
  .auto_resp_busy(auto_resp_busy), .channel_idle_flag(channel_idle_flag));
